/* File: design/usb_core_interrupt_flags.sv */
// Interrupt flags, masks and AXI4-Lite slave of the USB controller core
//
// The register offsets and the AXI4-Lite interface to the registers are this design's own decisions.
`timescale 1ns/1ns
`include "usb_irq_regs.svh"
// How it works
// [RULE1] Status read clears every flag it returned
// [RULE2] Software reads status only in direct mode
// [RULE3] Tx status: endpoint 0 bit 0, 1-4 above
// [RULE4] Rx status: endpoints 1-4 at bits 1-4
// [RULE5] Status bits read-only, reset zero, writes ignored
// [RULE6] Tx mask bits 0-4, reset to one
// [RULE7] Rx mask bits 1-4, reset one, bit 0 zero
// [RULE8] Bit 7 supply drop, A-side only
// [RULE9] Bit 6 session request, A-side only
// [RULE10] Bit 5 detach in host, session end otherwise
// [RULE11] Bit 4 attach, host mode only
// [RULE12] Bit 3 set on every new frame
// [RULE13] Bit 2 reset in peripheral, babble in host
// [RULE14] Bit 1 resume while suspended
// [RULE15] Bit 0 suspend, peripheral mode only
// [RULE16] Bus mask resets with bits 2,1 set
// [RULE17] Interrupt high while enabled flag pending
module usb_core_interrupt_flags
    import usb_irq_pkg::*;
#(
    parameter int ADDR_W = 8    // Register bus address width
) (
    // Clock and reset
    input  wire logic              clock_in,
    input  wire logic              arst_n_in,
    // Protocol engine events, one-cycle pulses
    input  wire logic [4:0]        tx_events_in,
    input  wire logic [3:0]        rx_events_in,
    input  wire usb_events_t       bus_events_in,
    input  wire usb_mode_t         mode_in,
    // AXI4-Lite write address and data
    input  wire logic [ADDR_W-1:0] awaddr_in,
    input  wire logic              awvalid_in,
    output logic                   awready_out,
    input  wire logic [31:0]       wdata_in,
    input  wire logic [3:0]        wstrb_in,
    input  wire logic              wvalid_in,
    output logic                   wready_out,
    // AXI4-Lite write response
    output logic [1:0]             bresp_out,
    output logic                   bvalid_out,
    input  wire logic              bready_in,
    // AXI4-Lite read
    input  wire logic [ADDR_W-1:0] araddr_in,
    input  wire logic              arvalid_in,
    output logic                   arready_out,
    output logic [31:0]            rdata_out,
    output logic [1:0]             rresp_out,
    output logic                   rvalid_out,
    input  wire logic              rready_in,
    // Core outputs
    output logic                   irq_out,
    output logic                   direct_irq_select_out
);

    // Decode needs at least the byte offsets used
    if (ADDR_W < 5 || ADDR_W > 32) begin : g_bad_addr
        $error("ADDR_W must lie between 5 and 32");
    end

    logic       rst_meta_q;     // First reset stage, read only by second
    logic       rst_n_q;        // Released reset used by the design
    irq_state_t q;              // Registered state
    irq_state_t d;              // Next state
    logic [7:0] rd_off;         // Read byte offset
    logic       rd_take;        // Read address taken this edge
    logic       wr_do;          // Held write is performed this edge
    logic [4:0] tx_set;         // Tx flags raised this cycle
    logic [4:0] rx_set;         // Rx flags raised this cycle
    usb_events_t bus_set;       // Qualified bus events
    logic [4:0] tx_clr;         // Tx flags cleared by a read
    logic [4:0] rx_clr;         // Rx flags cleared by a read
    logic [7:0] bus_clr;        // Bus flags cleared by a read

    // Reset release through two stages; assertion stays asynchronous
    always_ff @(posedge clock_in or negedge arst_n_in) begin
        if (!arst_n_in) begin
            rst_meta_q <= 1'b0;
            rst_n_q    <= 1'b0;
        end else begin
            rst_meta_q <= 1'b1;
            rst_n_q    <= rst_meta_q;
        end
    end

    // Handshake outputs are combinational from held state
    assign awready_out = !q.aw_held && !q.bvalid;
    assign wready_out  = !q.w_held && !q.bvalid;
    assign arready_out = !q.rvalid;
    assign rd_take     = arvalid_in && arready_out;
    assign rd_off      = 8'(araddr_in);
    assign wr_do       = q.aw_held && q.w_held && !q.bvalid;

    // Data outputs come straight from flip-flops
    assign bvalid_out            = q.bvalid;
    assign bresp_out             = q.bresp;
    assign rvalid_out            = q.rvalid;
    assign rdata_out             = q.rdata;
    assign rresp_out             = q.rresp;
    assign irq_out               = q.irq;
    assign direct_irq_select_out = q.direct_irq_select;

    // Endpoint flags pass straight through
    assign tx_set = tx_events_in;                   // [RULE3]
    assign rx_set = {rx_events_in, 1'b0};           // [RULE4]

    // Bus events qualified by mode before they reach a flag
    always_comb begin
        bus_set = bus_events_in;
        // Supply drop and session request only as A-side device
        bus_set.supply_drop_flag =
            bus_events_in.supply_drop_flag && mode_in.a_device;      // [RULE8]
        bus_set.session_request_flag =
            bus_events_in.session_request_flag && mode_in.a_device;  // [RULE9]
        // Engine reports detach or session end per mode alike
        bus_set.detach_flag = bus_events_in.detach_flag;             // [RULE10]
        // Attach has meaning only as host
        bus_set.attach_flag =
            bus_events_in.attach_flag && mode_in.host_mode;          // [RULE11]
        bus_set.frame_start_flag = bus_events_in.frame_start_flag;   // [RULE12]
        // Reset as peripheral, babble as host, one input
        bus_set.reset_babble_flag = bus_events_in.reset_babble_flag; // [RULE13]
        // Resume counts only while suspended
        bus_set.resume_flag =
            bus_events_in.resume_flag && mode_in.suspended;          // [RULE14]
        // Suspend counts only as peripheral
        bus_set.suspend_flag =
            bus_events_in.suspend_flag && !mode_in.host_mode;        // [RULE15]
    end

    // Next state: bus slave, flags and interrupt line
    always_comb begin
        d       = q;
        tx_clr  = '0;
        rx_clr  = '0;
        bus_clr = '0;

        // Capture write address and data in either order
        if (awvalid_in && awready_out) begin
            d.aw_held = 1'b1;
            d.aw_addr = 8'(awaddr_in);
        end
        if (wvalid_in && wready_out) begin
            d.w_held = 1'b1;
            d.w_data = wdata_in;
            d.w_strb = wstrb_in;
        end

        // Response retires on its handshake
        if (q.bvalid && bready_in) begin
            d.bvalid = 1'b0;
        end
        if (q.rvalid && rready_in) begin
            d.rvalid = 1'b0;
        end

        // Perform the write once both halves are in
        if (wr_do) begin
            d.aw_held = 1'b0;
            d.w_held  = 1'b0;
            d.bvalid  = 1'b1;
            d.bresp   = `RESP_OKAY;
            // Only the low byte carries writable bits
            if (q.aw_addr == `TX_MASK_OFF) begin
                if (q.w_strb[0]) begin
                    d.tx_mask = q.w_data[4:0];                       // [RULE6]
                end
            end else if (q.aw_addr == `RX_MASK_OFF) begin
                if (q.w_strb[0]) begin
                    d.rx_mask = q.w_data[4:0];                       // [RULE7]
                    d.rx_mask[`RX_RESV_BIT] = 1'b0;                  // [RULE7]
                end
            end else if (q.aw_addr == `BUS_MASK_OFF) begin
                if (q.w_strb[0]) begin
                    d.bus_mask = q.w_data[7:0];                      // [RULE16]
                end
            end else if (q.aw_addr == `CORE_CTRL_OFF) begin
                if (q.w_strb[0]) begin
                    d.direct_irq_select = q.w_data[`DIRECT_IRQ_BIT];
                end
            end else if (q.aw_addr == `TX_STAT_OFF || q.aw_addr == `RX_STAT_OFF ||
                         q.aw_addr == `BUS_STAT_OFF) begin
                // Status is read-only; accepted and dropped
                d.bresp = `RESP_OKAY;                                // [RULE5]
            end else begin
                // Unmapped address
                d.bresp = `RESP_SLVERR;
            end
        end

        // Read: data sampled from current flags, then flags cleared
        if (rd_take) begin
            d.rvalid = 1'b1;
            d.rdata  = '0;
            d.rresp  = `RESP_OKAY;
            if (rd_off == `TX_STAT_OFF) begin
                d.rdata[4:0] = q.tx_stat;                            // [RULE3]
                tx_clr       = '1;                                   // [RULE1]
            end else if (rd_off == `RX_STAT_OFF) begin
                d.rdata[4:0] = q.rx_stat;                            // [RULE4]
                rx_clr       = '1;                                   // [RULE1]
            end else if (rd_off == `TX_MASK_OFF) begin
                d.rdata[4:0] = q.tx_mask;
            end else if (rd_off == `RX_MASK_OFF) begin
                d.rdata[4:0] = q.rx_mask;
            end else if (rd_off == `BUS_STAT_OFF) begin
                d.rdata[7:0] = q.bus_stat;
                bus_clr      = '1;                                   // [RULE1]
            end else if (rd_off == `BUS_MASK_OFF) begin
                d.rdata[7:0] = q.bus_mask;
            end else if (rd_off == `CORE_CTRL_OFF) begin
                d.rdata[`DIRECT_IRQ_BIT] = q.direct_irq_select;
            end else begin
                d.rresp = `RESP_SLVERR;
            end
        end

        // Set wins over clear so a same-cycle event is never lost
        d.tx_stat  = (q.tx_stat & ~tx_clr) | tx_set;                 // [RULE1]
        d.rx_stat  = (q.rx_stat & ~rx_clr) | rx_set;                 // [RULE1]
        d.bus_stat = (q.bus_stat & ~bus_clr) | bus_set;              // [RULE1]
        d.rx_stat[`RX_RESV_BIT] = 1'b0;                              // [RULE4]

        // Line follows the flags it will hold next cycle
        d.irq = |(d.tx_stat & d.tx_mask) || |(d.rx_stat & d.rx_mask) ||
                |(d.bus_stat & d.bus_mask);                          // [RULE17]
    end

    // State register; only constants under reset
    always_ff @(posedge clock_in or negedge rst_n_q) begin
        if (!rst_n_q) begin
            q                   <= '0;                               // [RULE5]
            q.tx_mask           <= `TX_MASK_RST;                     // [RULE6]
            q.rx_mask           <= `RX_MASK_RST;                     // [RULE7]
            q.bus_mask          <= `BUS_MASK_RST;                    // [RULE16]
            q.direct_irq_select <= `CTRL_RST;
        end else begin
            q <= d;
        end
    end

    // Checks on the design's own behaviour
    default clocking cb @(posedge clock_in); endclocking
    default disable iff (!rst_n_q);

    logic wr_status;            // Held write targets a status register
    logic quiet_ev;             // No protocol event this cycle
    logic after_rst_q;          // High from the first clock after release
    assign wr_status = wr_do && (q.aw_addr == `TX_STAT_OFF ||
                       q.aw_addr == `RX_STAT_OFF || q.aw_addr == `BUS_STAT_OFF);
    assign quiet_ev  = tx_events_in == '0 && rx_events_in == '0 && bus_events_in == '0;
    always_ff @(posedge clock_in or negedge rst_n_q) begin
        if (!rst_n_q) begin
            after_rst_q <= 1'b0;
        end else begin
            after_rst_q <= 1'b1;
        end
    end

    read_clear_a: assert property ( // [RULE1]
        rd_take && rd_off == `TX_STAT_OFF && tx_events_in == '0
        |=> q.tx_stat == '0 && q.rvalid && q.rdata[4:0] == $past(q.tx_stat))
        else $error("tx status not cleared by read");
    tx_upper_a: assert property ( // [RULE3]
        rd_take && rd_off == `TX_STAT_OFF |=> q.rdata[31:5] == '0)
        else $error("tx status upper bits not zero");
    rx_resv_a: assert property ( // [RULE4]
        q.rx_stat[0] == 1'b0 && q.rx_mask[0] == 1'b0)
        else $error("rx reserved bit set");
    status_ro_a: assert property ( // [RULE5]
        wr_status && quiet_ev && !rd_take |=> $stable(q.tx_stat) &&
        $stable(q.rx_stat) && $stable(q.bus_stat))
        else $error("write changed a status flag");
    mask_reset_a: assert property ( // [RULE6]
        !after_rst_q |-> q.tx_mask == 5'h1F && q.rx_mask == 5'h1E)
        else $error("endpoint mask reset value wrong");
    mask_write_a: assert property ( // [RULE6]
        wr_do && q.aw_addr == `TX_MASK_OFF && q.w_strb[0]
        |=> q.tx_mask == $past(q.w_data[4:0]) && q.bvalid)
        else $error("tx mask write lost");
    supply_gate_a: assert property ( // [RULE8]
        !q.bus_stat.supply_drop_flag && !mode_in.a_device
        |=> !q.bus_stat.supply_drop_flag)
        else $error("supply drop set outside A-side");
    attach_gate_a: assert property ( // [RULE11]
        !q.bus_stat.attach_flag && !mode_in.host_mode |=> !q.bus_stat.attach_flag)
        else $error("attach set outside host mode");
    frame_set_a: assert property ( // [RULE12]
        bus_events_in.frame_start_flag |=> q.bus_stat.frame_start_flag)
        else $error("frame start flag not set");
    resume_gate_a: assert property ( // [RULE14]
        !q.bus_stat.resume_flag && !mode_in.suspended |=> !q.bus_stat.resume_flag)
        else $error("resume set while not suspended");
    suspend_gate_a: assert property ( // [RULE15]
        !q.bus_stat.suspend_flag && mode_in.host_mode |=> !q.bus_stat.suspend_flag)
        else $error("suspend set in host mode");
    bus_mask_rst_a: assert property ( // [RULE16]
        !after_rst_q |-> q.bus_mask == 8'h06)
        else $error("bus mask reset value wrong");
    irq_level_a: assert property ( // [RULE17]
        irq_out == (|(q.tx_stat & q.tx_mask) || |(q.rx_stat & q.rx_mask) ||
                    |(q.bus_stat & q.bus_mask)))
        else $error("interrupt line disagrees with flags");

    // Remaining mode gates, event sets and register writes
    session_gate_a: assert property ( // [RULE9]
        !q.bus_stat.session_request_flag && !mode_in.a_device
        |=> !q.bus_stat.session_request_flag)
        else $error("session request set outside A-side");
    detach_set_a: assert property ( // [RULE10]
        bus_events_in.detach_flag
        |=> q.bus_stat.detach_flag)
        else $error("detach flag not set");
    reset_set_a: assert property ( // [RULE13]
        bus_events_in.reset_babble_flag
        |=> q.bus_stat.reset_babble_flag)
        else $error("reset or babble flag not set");
    rx_read_a: assert property ( // [RULE4]
        rd_take && rd_off == `RX_STAT_OFF
        |=> q.rdata[31:5] == '0 && q.rdata[0] == 1'b0)
        else $error("rx status reserved bits not zero");
    rx_mask_wr_a: assert property ( // [RULE7]
        wr_do && q.aw_addr == `RX_MASK_OFF && q.w_strb[0]
        |=> q.rx_mask == {$past(q.w_data[4:1]), 1'b0})
        else $error("rx mask write wrong");
    bus_mask_wr_a: assert property ( // [RULE16]
        wr_do && q.aw_addr == `BUS_MASK_OFF && q.w_strb[0]
        |=> q.bus_mask == $past(q.w_data[7:0]))
        else $error("bus mask write lost");
    bus_clear_a: assert property ( // [RULE1]
        rd_take && rd_off == `BUS_STAT_OFF && bus_set == '0
        |=> q.bus_stat == '0 && q.rdata[7:0] == $past(q.bus_stat))
        else $error("bus status not cleared by read");
    irq_set_a: assert property ( // [RULE17]
        bus_set.reset_babble_flag && q.bus_mask[2] && !wr_do
        |=> irq_out)
        else $error("enabled event did not raise interrupt");

    // Engine reports an event that the mode must drop
    gate_hit_c: cover property (bus_events_in.attach_flag && !mode_in.host_mode);
    tx_read_c: cover property (rd_take && rd_off == `TX_STAT_OFF && q.tx_stat != '0);
    mask_wr_c: cover property (wr_do && q.aw_addr == `BUS_MASK_OFF);
    irq_rise_c: cover property ($rose(irq_out));
    set_clear_c: cover property (rd_take && rd_off == `BUS_STAT_OFF && bus_set != '0);

endmodule : usb_core_interrupt_flags

/* File: design/usb_irq_regs.svh */
// Register offsets, field positions and reset values of the interrupt block
`ifndef USB_IRQ_REGS_SVH
`define USB_IRQ_REGS_SVH

// Byte offsets on the register bus
`define TX_STAT_OFF    8'h00
`define RX_STAT_OFF    8'h04
`define TX_MASK_OFF    8'h08
`define RX_MASK_OFF    8'h0C
`define BUS_STAT_OFF   8'h10
`define BUS_MASK_OFF   8'h14
`define CORE_CTRL_OFF  8'h18

// Implemented field widths
`define EP_FLAG_W      5
`define BUS_FLAG_W     8

// Reset values
`define TX_MASK_RST    5'h1F
`define RX_MASK_RST    5'h1E
`define BUS_MASK_RST   8'h06
`define CTRL_RST       1'h0

// Field positions
`define RX_RESV_BIT    0
`define DIRECT_IRQ_BIT 0

// Bus responses
`define RESP_OKAY      2'h0
`define RESP_SLVERR    2'h2

`endif

/* File: design/usb_irq_pkg.sv */
// Types shared by the interrupt block and its bench
package usb_irq_pkg;

    // Common bus events, bit 7 down to bit 0
    typedef struct packed {
        logic supply_drop_flag;
        logic session_request_flag;
        logic detach_flag;
        logic attach_flag;
        logic frame_start_flag;
        logic reset_babble_flag;
        logic resume_flag;
        logic suspend_flag;
    } usb_events_t;

    // Operating mode seen by the protocol engine
    typedef struct packed {
        logic host_mode;
        logic a_device;
        logic suspended;
    } usb_mode_t;

    // Whole state of the block
    typedef struct packed {
        logic [4:0]  tx_stat;
        logic [4:0]  rx_stat;
        logic [4:0]  tx_mask;
        logic [4:0]  rx_mask;
        usb_events_t bus_stat;
        logic [7:0]  bus_mask;
        logic        direct_irq_select;
        logic        aw_held;
        logic [7:0]  aw_addr;
        logic        w_held;
        logic [31:0] w_data;
        logic [3:0]  w_strb;
        logic        bvalid;
        logic [1:0]  bresp;
        logic        rvalid;
        logic [31:0] rdata;
        logic [1:0]  rresp;
        logic        irq;
    } irq_state_t;

endpackage : usb_irq_pkg

/* File: tb/usb_engine_model.sv */
// Protocol engine stand-in: turns bench requests into one-cycle event pulses
`timescale 1ns/1ns
module usb_engine_model
    import usb_irq_pkg::*;
(
    // Clock
    input  wire logic        clock_in,
    // Requests from the bench
    input  wire logic        fire_in,
    input  wire logic [4:0]  tx_req_in,
    input  wire logic [3:0]  rx_req_in,
    input  wire usb_events_t bus_req_in,
    input  wire usb_mode_t   mode_req_in,
    // Towards the block
    output logic [4:0]       tx_events_out,
    output logic [3:0]       rx_events_out,
    output usb_events_t      bus_events_out,
    output usb_mode_t        mode_out
);
    // Quiet start so the block never sees unknown events
    initial begin
        tx_events_out  = 5'h0;
        rx_events_out  = 4'h0;
        bus_events_out = 8'h00;
        mode_out       = 3'h0;
    end
    // Events last one cycle only; a held level would set flags every cycle
    always @(posedge clock_in) begin
        tx_events_out  <= fire_in ? tx_req_in : 5'h0;
        rx_events_out  <= fire_in ? rx_req_in : 4'h0;
        bus_events_out <= fire_in ? bus_req_in : 8'h00;
        mode_out       <= mode_req_in;
    end
endmodule : usb_engine_model

/* File: tb/test_usb_core_interrupt_flags.sv */
// Self-checking bench of the interrupt flag block
`timescale 1ns/1ns
`include "usb_irq_regs.svh"
module test_usb_core_interrupt_flags;
    import usb_irq_pkg::*;
    logic clk = 0, arst_n = 0, fire = 0;       // Clock, reset, event request
    logic [7:0] awaddr = 0, araddr = 0;        // Bus addresses
    logic awvalid = 0, wvalid = 0, bready = 0, arvalid = 0, rready = 0;
    logic [31:0] wdata = 0, rd, seed = 32'h0000_A4D2; // Write data, read data, generator
    logic [3:0] wstrb = 0, rx_req = 0, rx_ev;  // Strobes, rx events
    logic [4:0] tx_req = 0, tx_ev;             // Tx events
    usb_events_t bus_req = 0, bus_ev;          // Common bus events
    usb_mode_t mode_req = 0, mode;             // Operating mode
    logic awready, wready, bvalid, arready, rvalid, irq, dsel; // Block outputs
    logic [1:0] bresp, rresp, resp;            // Responses
    int fails = 0, num_checks = 0, cycles = 0; // Counters
    logic [7:0] offs [7] = '{`CORE_CTRL_OFF, `TX_STAT_OFF, `RX_STAT_OFF, `TX_MASK_OFF,
                             `RX_MASK_OFF, `BUS_STAT_OFF, `BUS_MASK_OFF};
    logic [31:0] rst_v [7] = '{0, 0, 0, `TX_MASK_RST, `RX_MASK_RST, 0, `BUS_MASK_RST};
    logic [31:0] ones_v [7] = '{1, 0, 0, 32'h0000_001F, 32'h0000_001E, 0, 32'h0000_00FF};
    logic [31:0] exp_s [3];                    // Expected tx, rx, bus status
    logic [31:0] msk [3];                      // Masks in force
    logic [7:0] stat_offs [3] = '{`TX_STAT_OFF, `RX_STAT_OFF, `BUS_STAT_OFF};
    logic [7:0] mask_offs [3] = '{`TX_MASK_OFF, `RX_MASK_OFF, `BUS_MASK_OFF};

    usb_engine_model engine (.clock_in(clk), .fire_in(fire), .tx_req_in(tx_req),
        .rx_req_in(rx_req), .bus_req_in(bus_req), .mode_req_in(mode_req),
        .tx_events_out(tx_ev), .rx_events_out(rx_ev), .bus_events_out(bus_ev),
        .mode_out(mode));
    usb_core_interrupt_flags dut (.clock_in(clk), .arst_n_in(arst_n), .tx_events_in(tx_ev),
        .rx_events_in(rx_ev), .bus_events_in(bus_ev), .mode_in(mode), .awaddr_in(awaddr),
        .awvalid_in(awvalid), .awready_out(awready), .wdata_in(wdata), .wstrb_in(wstrb),
        .wvalid_in(wvalid), .wready_out(wready), .bresp_out(bresp), .bvalid_out(bvalid),
        .bready_in(bready), .araddr_in(araddr), .arvalid_in(arvalid),
        .arready_out(arready), .rdata_out(rd), .rresp_out(rresp), .rvalid_out(rvalid),
        .rready_in(rready), .irq_out(irq), .direct_irq_select_out(dsel));

    // 20 MHz clock
    always #25 clk = ~clk;
    // Watchdog; the whole run needs under two thousand cycles
    always @(posedge clk) begin
        cycles++;
        if (cycles == 20000) begin
            fails++;
            $display("unexpected at %0t: run hung", $time);
            stop_test();
        end
    end

    // Repeatable pseudo-random numbers
    function automatic logic [31:0] xorshift();
        seed ^= seed << 13;
        seed ^= seed >> 17;
        seed ^= seed << 5;
        return seed;
    endfunction : xorshift
    // Common flags that the mode lets through; detach, frame, reset pass always
    function automatic logic [31:0] bus_expect(input usb_events_t e, input usb_mode_t m);
        if (!m.a_device) {e.supply_drop_flag, e.session_request_flag} = 2'b00;
        if (!m.host_mode) e.attach_flag = 1'b0;
        if (!m.suspended) e.resume_flag = 1'b0;
        if (m.host_mode) e.suspend_flag = 1'b0;
        return {24'h0, e};
    endfunction : bus_expect

    // Word comparison
    task automatic check_word(input logic [31:0] got, input logic [31:0] exp, input string s);
        num_checks++;
        if (got !== exp) begin
            fails++;
            $display("unexpected at %0t: %s got %h want %h", $time, s, got, exp);
        end
    endtask : check_word
    // Single flag comparison
    task automatic check_bit(input logic got, input logic exp, input string s);
        check_word({31'h0, got}, {31'h0, exp}, s);
    endtask : check_bit
    // Write one word; handshakes judged on the value settled before the edge
    task automatic axi_write(input logic [7:0] a, input logic [31:0] d);
        logic aw_hs, w_hs, b_hs;
        @(posedge clk);
        {awaddr, wdata, wstrb} <= {a, d, 4'hF};
        {awvalid, wvalid, bready} <= 3'b111;
        do begin
            @(negedge clk);
            aw_hs = awvalid && awready;
            w_hs = wvalid && wready;
            @(posedge clk);
            if (aw_hs) awvalid <= 0;
            if (w_hs) wvalid <= 0;
        end while (awvalid || wvalid);
        do begin
            @(negedge clk);
            b_hs = bvalid;
            resp = bresp;
            @(posedge clk);
        end while (!b_hs);
        bready <= 0;
    endtask : axi_write
    // Read one word into rd_word and resp
    logic [31:0] rd_word;
    task automatic axi_read(input logic [7:0] a);
        logic hs;
        @(posedge clk);
        {araddr, arvalid, rready} <= {a, 2'b11};
        do begin
            @(negedge clk);
            hs = arready;
            @(posedge clk);
        end while (!hs);
        arvalid <= 0;
        do begin
            @(negedge clk);
            hs = rvalid;
            {rd_word, resp} = {rd, rresp};
            @(posedge clk);
        end while (!hs);
        rready <= 0;
    endtask : axi_read
    // One burst of engine events, seen by the block one edge later
    task automatic pulse(input logic [4:0] t, input logic [3:0] r, input usb_events_t b,
                         input usb_mode_t m);
        @(posedge clk);
        {fire, tx_req, rx_req, bus_req, mode_req} <= {1'b1, t, r, b, m};
        @(posedge clk);
        fire <= 0;
    endtask : pulse
    // Counts and verdict
    task automatic stop_test();
        $display("checks %0d mismatches %0d", num_checks, fails);
        if (fails == 0 && num_checks > 0)
            $display("Finished cleanly");
        else
            $display("Finished with errors");
        $finish;
    endtask : stop_test

    // Main sequence
    initial begin
        logic [4:0] t;
        logic [3:0] r;
        usb_events_t b;
        usb_mode_t m;
        repeat (8) @(posedge clk);
        arst_n <= 1;
        repeat (3) @(posedge clk);
        // Reset values of every register
        for (int i = 0; i < 7; i++) begin
            axi_read(offs[i]);
            check_word(rd_word, rst_v[i], "reset value");
            // Status reads are destructive; enter direct mode before the first one
            if (i == 0) axi_write(`CORE_CTRL_OFF, 32'h0000_0001);
        end
        check_bit(irq, 1'b0, "irq after reset");
        $display("test reset values done");
        // Access kinds: all ones everywhere, status ignores it, reserved bits stay 0
        for (int i = 0; i < 7; i++) axi_write(offs[i], 32'hFFFF_FFFF);
        for (int i = 0; i < 7; i++) begin
            axi_read(offs[i]);
            check_word(rd_word, ones_v[i], "access kind");
        end
        check_bit(dsel, 1'b1, "direct mode bit");
        axi_write(8'h1C, 32'h0000_0001);
        check_word({30'h0, resp}, {30'h0, `RESP_SLVERR}, "unmapped write");
        axi_read(8'h1C);
        check_word({resp, rd_word}, {`RESP_SLVERR, 32'h0}, "unmapped read");
        $display("test access kinds done");
        // Random events under random masks; first eight sweep all modes with all events
        for (int it = 0; it < 40; it++) begin
            msk = '{xorshift() & 32'h1F, xorshift() & 32'h1E, xorshift() & 32'hFF};
            for (int g = 0; g < 3; g++) axi_write(mask_offs[g], msk[g]);
            exp_s = '{0, 0, 0};
            for (int p = 0; p < 3; p++) begin
                {t, r, b, m} = 20'(xorshift());
                if (it < 8) {t, r, b, m} = {17'h1_FFFF, it[2:0]};
                pulse(t, r, b, m);
                exp_s[0] |= t;
                exp_s[1] |= {r, 1'b0};
                exp_s[2] |= bus_expect(b, m);
            end
            @(posedge clk);
            @(negedge clk);
            check_bit(irq, |((exp_s[0] & msk[0]) | (exp_s[1] & msk[1]) | (exp_s[2] & msk[2])),
                      "irq while pending");
            for (int g = 0; g < 3; g++) begin
                axi_read(stat_offs[g]);
                check_word(rd_word, exp_s[g], "status");
                axi_read(stat_offs[g]);
                check_word(rd_word, 0, "status after read");
            end
            check_bit(irq, 1'b0, "irq after clearing");
        end
        $display("test random events done");
        stop_test();
    end
endmodule : test_usb_core_interrupt_flags
